/* File: fei_conc.sv */
`timescale 1ns/100ps
`default_nettype none
// concentrator end: makes the serial clock by dividing clk_sys
module fei_conc (
    input  wire logic                         clk_sys,
    input  wire logic                         rst_n,
    fei_if.conc                               link,
    input  wire logic                         start,
    input  wire logic                         write,
    input  wire logic [fei_pkg::SERIAL_W-1:0] key_serial,
    input  wire logic [fei_pkg::INDEX_W-1:0]  key_index,
    input  wire logic                         key_set_flag,
    input  wire logic [fei_pkg::INDEX_W-1:0]  expect_index,
    output logic                              busy,
    output logic                              done,
    output logic [fei_pkg::SERIAL_W-1:0]      rd_serial,
    output logic                              rd_flag,
    output logic [fei_pkg::INDEX_W-1:0]       rd_index,
    output logic                              rd_verify_ok
);
    import fei_pkg::*;
    fei_state_t               state_reg;
    logic [CNT_W-1:0]         bit_reg;
    logic [2:0]               div_reg;
    logic [FRAME_BITS-1:0]    shift_reg;   // key out / data in
    logic                     wr_reg;
    logic                     sclk_reg;
    logic                     sel_reg;
    logic                     key_reg;
    logic [INDEX_W-1:0]       exp_reg;
    logic                     din_s1_reg;
    logic                     din_s2_reg;
    logic                     take;        // start accepted this cycle
    logic                     running;     // a frame is on the wire
    logic                     tick;        // a serial clock half period ends
    logic                     rise;        // serial clock goes high next
    logic                     fall;        // serial clock goes low next, read bit taken
    logic                     finish;      // seventy clocks done, select drops next

    // a half period is SCLK_DIV system cycles; both halves share one divider
    function automatic logic half_end(input logic [2:0] div);
        return div == 3'(SCLK_DIV-1);
    endfunction

    // sampled unit output passes two flops
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_reg <= 1'b0;
            din_s2_reg <= 1'b0;
        end else begin
            din_s1_reg <= link.unit_serial_out;
            din_s2_reg <= din_s1_reg;
        end
    end

    // start is refused while a frame runs
    assign take    = state_reg == FEI_IDLE && start;
    assign running = state_reg == FEI_SETUP || state_reg == FEI_HIGH || state_reg == FEI_LOW;
    assign tick    = running && half_end(div_reg);
    assign finish  = tick && state_reg == FEI_LOW && bit_reg == CNT_W'(FRAME_BITS);
    assign rise    = tick && state_reg != FEI_HIGH && !finish;
    assign fall    = tick && state_reg == FEI_HIGH;

    // [RL3] one read or key-write frame per start; software sequences phases
    // [RL17] rerunning after a power loss is left to software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= FEI_IDLE;
        end else begin
            case (state_reg)
                FEI_IDLE: begin
                    if (take) begin
                        state_reg <= FEI_SETUP;
                    end
                end
                FEI_SETUP: begin
                    if (tick) begin
                        state_reg <= FEI_HIGH;
                    end
                end
                FEI_HIGH: begin
                    if (tick) begin
                        state_reg <= FEI_LOW;
                    end
                end
                FEI_LOW: begin
                    if (finish) begin
                        state_reg <= FEI_DONE;
                    end else if (tick) begin
                        state_reg <= FEI_HIGH;
                    end
                end
                FEI_DONE: begin
                    state_reg <= FEI_IDLE;
                end
                default: begin
                    state_reg <= FEI_IDLE;
                end
            endcase
        end
    end

    // half-period divider; rests at zero so every frame opens with the same gap
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= '0;
        end else if (!running || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    // counts serial clock falls, one per frame bit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bit_reg <= '0;
        end else if (take) begin
            bit_reg <= '0;
        end else if (fall) begin
            bit_reg <= bit_reg + 7'h01;
        end
    end

    // request held from start, so input changes cannot disturb a running frame
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg  <= 1'b0;
            exp_reg <= '0;
        end else if (take) begin
            wr_reg  <= write;
            exp_reg <= expect_index;
        end
    end

    // [RL12] [RL13] key order: serial, update bit, index msb first
    // [RL10] read bits enter at the fall from the synced copy, settled two cycles
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= '0;
        end else if (take) begin
            shift_reg <= {key_serial, key_set_flag, key_index};
        end else if (fall) begin
            shift_reg <= {shift_reg[FRAME_BITS-2:0], din_s2_reg};
        end
    end

    // [RL6] [RL11] select stands over seventy clocks
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sel_reg <= 1'b0;
        end else if (take) begin
            sel_reg <= 1'b1;
        end else if (finish) begin
            sel_reg <= 1'b0;
        end
    end

    // serial clock idles low, so the unit sees no edge between frames
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg <= 1'b0;
        end else if (rise) begin
            sclk_reg <= 1'b1;
        end else if (fall) begin
            sclk_reg <= 1'b0;
        end
    end

    // [RL14] key changes with rising edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_reg <= 1'b0;
        end else if (rise) begin
            key_reg <= shift_reg[FRAME_BITS-1];
        end else if (finish) begin
            key_reg <= 1'b0;
        end
    end

    // done pulses for one cycle once select has dropped
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= state_reg == FEI_DONE;
        end
    end

    // read results latched at frame end
    // [RL16] verify flag and index against expected port
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_serial    <= '0;
            rd_flag      <= 1'b0;
            rd_index     <= '0;
            rd_verify_ok <= 1'b0;
        end else if (state_reg == FEI_DONE && !wr_reg) begin
            rd_serial    <= shift_reg[FRAME_BITS-1 -: SERIAL_W];
            rd_flag      <= shift_reg[INDEX_W];
            rd_index     <= shift_reg[INDEX_W-1:0];
            // [RL1] index must equal port number
            rd_verify_ok <= shift_reg[INDEX_W] && shift_reg[INDEX_W-1:0] == exp_reg;
        end
    end

    assign busy                    = state_reg != FEI_IDLE;
    assign link.ident_serial_clock = sclk_reg;
    assign link.ident_select       = sel_reg;
    // [RL4] [RL5] direction low read, high write
    assign link.ident_direction    = sel_reg ? wr_reg : RD_DIR;
    assign link.key_serial_in      = key_reg;
endmodule
`default_nettype wire

/* File: fei_if.sv */
`timescale 1ns/100ps
`default_nettype none
// serial identification link between concentrator and one unit
interface fei_if;
    logic ident_serial_clock;
    logic ident_select;
    logic ident_direction;
    logic key_serial_in;
    logic unit_serial_out;
    modport conc (output ident_serial_clock, output ident_select, output ident_direction,
                  output key_serial_in, input unit_serial_out);
    modport unit (input ident_serial_clock, input ident_select, input ident_direction,
                  input key_serial_in, output unit_serial_out);
endinterface
`default_nettype wire

/* File: fei_pkg.sv */
// What the document requires of this block
// [RL1] unit identified by 5-bit port index 0..31
// [RL2] unit presents a 64-bit unique serial number
// [RL3] read all serials, then broadcast index keys
// [RL4] both phases via broadcast config operations
// [RL5] serial clock, select, direction, key, output
// [RL6] read: select high, direction low, 70 clocks
// [RL7] read cycles 0-63 return serial, msb first
// [RL8] read cycle 64 returns ID-set flag
// [RL9] read cycles 65-69 return index or zeros
// [RL10] unit drives after rise, concentrator samples fall
// [RL11] key write: direction high, 70 key bits
// [RL12] key bit 64 is one to set flag
// [RL13] last five key bits carry index, msb first
// [RL14] key changes on rise, unit samples fall
// [RL15] matching unit loads index, sets flag after
// [RL16] re-read all units and verify flag, index
// [RL17] rerun whole procedure after any power loss; the code leaves the rerun to software
// [RL18] unit exposes index read-only, tags packets; the code has no packets, only the index output
// [RL19] unit filters operations by its index; the code does no such filtering
// [RL20] power-up clears flag and index to zero
`default_nettype none
package fei_pkg;
    localparam int SERIAL_W    = 64;
    localparam int INDEX_W     = 5;
    localparam int FRAME_BITS  = 70;
    localparam int FLAG_POS    = 64;
    localparam int PORT_COUNT  = 32;
    localparam int CNT_W       = 7;
    localparam int SCLK_DIV    = 4;   // system cycles per serial clock half period
    localparam logic RD_DIR    = 1'b0;
    localparam logic WR_DIR    = 1'b1;
    typedef enum logic [2:0] {FEI_IDLE, FEI_SETUP, FEI_HIGH, FEI_LOW, FEI_DONE} fei_state_t;
endpackage
`default_nettype wire

/* File: fei_sva.sv */
`timescale 1ns/100ps
`default_nettype none
// link protocol checker; the link clock is divided from clk_sys, so one domain covers it
module fei_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic ident_serial_clock,
    input wire logic ident_select,
    input wire logic ident_direction,
    input wire logic key_serial_in,
    input wire logic unit_serial_out
);
    logic       sclk_q_reg;
    logic [7:0] rise_cnt_reg;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // count serial clock rises within one frame; cleared while deselected
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q_reg   <= 1'b0;
            rise_cnt_reg <= 8'h00;
        end else begin
            sclk_q_reg   <= ident_serial_clock;
            rise_cnt_reg <= !ident_select ? 8'h00 : rise_cnt_reg + 8'(ident_serial_clock && !sclk_q_reg);
        end
    end
    AST_SCLK_IDLE: assert property (!ident_select |-> !ident_serial_clock)
        else $error("serial clock active outside a frame");
    AST_START_GAP: assert property ($rose(ident_select) |-> !ident_serial_clock[*4] ##1 ident_serial_clock)
        else $error("first serial clock rise misplaced after select");
    AST_HIGH_HALF: assert property ($rose(ident_serial_clock) |-> ident_serial_clock[*4] ##1 !ident_serial_clock)
        else $error("serial clock high phase wrong length");
    AST_COUNT_END: assert property ($fell(ident_select) |-> rise_cnt_reg == 8'h46)
        else $error("frame did not carry seventy clocks");
    AST_COUNT_MAX: assert property (ident_select |-> rise_cnt_reg <= 8'h46)
        else $error("frame carries too many clocks");
    AST_DIR_HOLD: assert property (ident_select && $past(ident_select) |-> $stable(ident_direction))
        else $error("direction changed inside a frame");
    AST_KEY_ON_RISE: assert property (ident_select && $past(ident_select) && ident_direction
        && rise_cnt_reg < 8'h46 && $changed(key_serial_in) |-> $rose(ident_serial_clock))
        else $error("key line changed away from a rising edge");
    AST_OUT_ON_RISE: assert property (ident_select && $past(ident_select) && !ident_direction
        && $changed(unit_serial_out) |-> $rose(ident_serial_clock))
        else $error("unit output changed away from a rising edge");
    AST_OUT_AT_FALL: assert property ($fell(ident_serial_clock) && ident_select && !ident_direction
        |-> $stable(unit_serial_out))
        else $error("unit output moving at the sampling edge");
endmodule
`default_nettype wire

/* File: fei_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module fei_tb_top;
    import fei_pkg::*;
    localparam logic [63:0] SER = 64'hA5C3_0F96_1E2D_B487;
    logic        clk_sys, rst_n = 1'b0, rst_unit_n = 1'b0, start = 1'b0, write = 1'b0;
    logic        key_set_flag = 1'b0, busy, done, rd_flag, rd_verify_ok, id_set;
    logic [63:0] key_serial = 64'h0, rd_serial;
    logic [4:0]  key_index = 5'h00, expect_index = 5'h00, rd_index, assigned_port_index;
    logic [69:0] cap;
    int          fails = 0, n_compared = 0;
    fei_if link_if ();
    fei_conc i_fei_conc (.clk_sys(clk_sys), .rst_n(rst_n), .link(link_if), .start(start),
        .write(write), .key_serial(key_serial), .key_index(key_index), .key_set_flag(key_set_flag),
        .expect_index(expect_index), .busy(busy), .done(done), .rd_serial(rd_serial),
        .rd_flag(rd_flag), .rd_index(rd_index), .rd_verify_ok(rd_verify_ok));
    fei_unit i_fei_unit (.rst_n(rst_unit_n), .link(link_if), .unique_serial_number(SER),
        .assigned_port_index(assigned_port_index), .id_set(id_set));
    fei_sva i_fei_sva (.clk_sys(clk_sys), .rst_n(rst_n),
        .ident_serial_clock(link_if.ident_serial_clock), .ident_select(link_if.ident_select),
        .ident_direction(link_if.ident_direction), .key_serial_in(link_if.key_serial_in),
        .unit_serial_out(link_if.unit_serial_out));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // wire capture at every serial fall, the same edge the receiving end samples on
    always @(negedge link_if.ident_serial_clock) begin
        if (link_if.ident_select) begin
            cap = {cap[68:0], link_if.ident_direction ? link_if.key_serial_in : link_if.unit_serial_out};
        end
    end
    task automatic chk(input string name, input logic [69:0] exp, input logic [69:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // one frame; the wire is checked against the seventy bits it must carry
    task automatic frame(input logic wr, input logic [63:0] ser, input logic [4:0] idx,
                         input logic flg, input logic [4:0] exp_idx);
        int n;
        write = wr;
        key_serial = ser;
        key_index = idx;
        key_set_flag = flg;
        expect_index = exp_idx;
        start = 1'b1;
        @(posedge clk_sys);
        #1;
        start = 1'b0;
        chk("busy", 70'(1'b1), 70'(busy));
        for (n = 0; n < 1000 && done !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("done", 70'(1'b1), 70'(done));
        chk("busy idle", 70'(1'b0), 70'(busy));
        if (n == 1000) complete_run();
        chk("wire frame", {ser, flg, idx}, cap);
    endtask
    task automatic read_chk(input logic flg, input logic [4:0] idx, input logic [4:0] exp_idx,
                            input logic ok);
        frame(RD_DIR, SER, idx, flg, exp_idx);
        chk("rd_serial", 70'(SER), 70'(rd_serial));
        chk("rd_flag", 70'(flg), 70'(rd_flag));
        chk("rd_index", 70'(idx), 70'(rd_index));
        chk("rd_verify_ok", 70'(ok), 70'(rd_verify_ok));
    endtask
    task automatic key_chk(input logic [63:0] ser, input logic [4:0] idx, input logic flg,
                           input logic set, input logic [4:0] exp_idx);
        frame(WR_DIR, ser, idx, flg, 5'h00);
        chk("id_set", 70'(set), 70'(id_set));
        chk("assigned_port_index", 70'(exp_idx), 70'(assigned_port_index));
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        rst_unit_n = 1'b1;
        read_chk(1'b0, 5'h00, 5'h00, 1'b0);
        $display("test unassigned read finished");
        key_chk(SER ^ 64'h1, 5'h15, 1'b1, 1'b0, 5'h00);
        key_chk(SER, 5'h1F, 1'b1, 1'b1, 5'h1F);
        read_chk(1'b1, 5'h1F, 5'h1F, 1'b1);
        $display("test assign and verify finished");
        key_chk(SER, 5'h0A, 1'b0, 1'b1, 5'h0A);
        read_chk(1'b1, 5'h0A, 5'h15, 1'b0);
        $display("test flag keep and wrong index finished");
        rst_unit_n = 1'b0;
        @(posedge clk_sys);
        #1;
        rst_unit_n = 1'b1;
        read_chk(1'b0, 5'h00, 5'h00, 1'b0);
        $display("test unit power loss finished");
        complete_run();
    end
endmodule
`default_nettype wire

/* File: fei_unit.sv */
`timescale 1ns/100ps
`default_nettype none
// unit end: runs only on the link serial clock; power-up reset is rst_n
module fei_unit (
    input  wire logic                         rst_n,
    fei_if.unit                               link,
    input  wire logic [fei_pkg::SERIAL_W-1:0] unique_serial_number,
    output logic [fei_pkg::INDEX_W-1:0]       assigned_port_index,
    output logic                              id_set
);
    import fei_pkg::*;
    logic [CNT_W-1:0]    rcnt_reg;   // rise-side bit counter for read output
    logic [CNT_W-1:0]    fcnt_reg;   // fall-side bit counter for key capture
    logic                out_reg;
    logic                match_reg;
    logic                set_req_reg;
    logic [INDEX_W-1:0]  idx_sh_reg;
    logic                frame_rst_n;   // low at power-up and between frames

    // serial number bit sent or compared at a given frame bit, msb first
    function automatic logic serial_bit(input logic [CNT_W-1:0]    cnt,
                                        input logic [SERIAL_W-1:0] ser);
        return ser[SERIAL_W-1-int'(cnt)];
    endfunction

    // the serial clock stops between frames, so no edge could clear the counters;
    // select itself clears them, and it is a register output at the far end
    assign frame_rst_n = rst_n && link.ident_select;

    // [RL10] drive output after rising edge
    always_ff @(posedge link.ident_serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rcnt_reg <= '0;
            out_reg  <= 1'b0;
        end else begin
            rcnt_reg <= rcnt_reg + 7'h01;
            // [RL7] serial msb first
            if (rcnt_reg < CNT_W'(SERIAL_W))
                out_reg <= serial_bit(rcnt_reg, unique_serial_number);
            // [RL8] flag bit
            else if (rcnt_reg == CNT_W'(FLAG_POS))
                out_reg <= id_set;
            // [RL9] index or zero
            else if (rcnt_reg < CNT_W'(FRAME_BITS))
                out_reg <= id_set & assigned_port_index[FRAME_BITS-1-int'(rcnt_reg)];
            else
                out_reg <= 1'b0;
        end
    end
    assign link.unit_serial_out = out_reg;

    // [RL14] capture key on falling edge
    always_ff @(negedge link.ident_serial_clock or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            fcnt_reg    <= '0;
            match_reg   <= 1'b1;
            set_req_reg <= 1'b0;
            idx_sh_reg  <= '0;
        end else if (link.ident_direction == WR_DIR) begin
            if (fcnt_reg != CNT_W'(FRAME_BITS))
                fcnt_reg <= fcnt_reg + 7'h01;
            // [RL15] compare serial bit by bit
            if (fcnt_reg < CNT_W'(SERIAL_W) &&
                link.key_serial_in != serial_bit(fcnt_reg, unique_serial_number))
                match_reg <= 1'b0;
            // [RL12] flag-update bit
            if (fcnt_reg == CNT_W'(FLAG_POS))
                set_req_reg <= link.key_serial_in;
            // [RL13] shift index msb first
            if (fcnt_reg > CNT_W'(FLAG_POS) && fcnt_reg < CNT_W'(FRAME_BITS))
                idx_sh_reg <= {idx_sh_reg[INDEX_W-2:0], link.key_serial_in};
        end
    end

    // [RL15] load on the same fall that takes the fifth index bit
    // [RL20] cleared at power-up
    always_ff @(negedge link.ident_serial_clock or negedge rst_n) begin
        if (!rst_n) begin
            assigned_port_index <= '0;
            id_set              <= 1'b0;
        end else if (link.ident_select && link.ident_direction == WR_DIR
                     && fcnt_reg == CNT_W'(FRAME_BITS-1) && match_reg) begin
            // [RL18] index exposed read-only
            assigned_port_index <= {idx_sh_reg[INDEX_W-2:0], link.key_serial_in};
            if (set_req_reg)
                id_set <= 1'b1;
        end
    end
endmodule
`default_nettype wire
